// ==== hw/dbh_defines.vh ====
// constants for the double-buffered converter host controller
// assumes a 50 MHz core clock and a converter driven by active-low pins
// Behaviour
// - strobe gates both latches; only enabled latches take data
// - group update: load each input latch, then one strobe for all
// - single-buffered: both enables held low permanently
// - single-buffered strobe stays low at least 80 ns
// - both enables and strobe low, clear high: data flows straight through
`ifndef DBH_DEFINES_VH
`define DBH_DEFINES_VH

`define DBH_CLK_PERIOD_NS   20
`define DBH_SETUP_NS        20
`define DBH_SETUP_CYC       ((`DBH_SETUP_NS + `DBH_CLK_PERIOD_NS - 1) / `DBH_CLK_PERIOD_NS)
`define DBH_STROBE_MIN_NS   80
`define DBH_STROBE_CYC      ((`DBH_STROBE_MIN_NS + `DBH_CLK_PERIOD_NS - 1) / `DBH_CLK_PERIOD_NS)
`define DBH_CLEAR_MIN_NS    80
`define DBH_CLEAR_CYC       ((`DBH_CLEAR_MIN_NS + `DBH_CLK_PERIOD_NS - 1) / `DBH_CLK_PERIOD_NS)
`define DBH_BIPOLAR_ZERO    16'h0000

`define DBH_OP_LOAD         2'h0
`define DBH_OP_UPDATE       2'h1
`define DBH_OP_LOAD_UPDATE  2'h2
`define DBH_OP_CLEAR        2'h3

`endif

// ==== hw/dbh_host.v ====
// host controller driving the double-buffered converter write pins
// assumes requests arrive synchronous to core_clk; the converter is
// outside and holds its own latches
`include "dbh_defines.vh"

module dbh_host #(
    parameter DATA_W      = 16,
    parameter NUM_CONV    = 1,
    parameter SINGLE_BUF  = 0
) (
    // clock and reset
    input  wire                core_clk,
    input  wire                reset,
    // user request
    input  wire                req_valid,
    input  wire [1:0]          req_op,
    input  wire [DATA_W-1:0]   req_data,
    input  wire [NUM_CONV-1:0] req_sel,
    output reg                 req_ready_ff,
    output reg                 done_ff,
    // converter pins
    output reg  [DATA_W-1:0]   data_bus_ff,
    output reg  [NUM_CONV-1:0] input_latch_enable_n_ff,
    output reg  [NUM_CONV-1:0] converter_latch_enable_n_ff,
    output reg                 write_n_ff,
    output reg                 clear_n_ff
);

//------------------------------------------------------------
// states
//------------------------------------------------------------
localparam ST_IDLE  = 2'h0;
localparam ST_SETUP = 2'h1;
localparam ST_WRITE = 2'h2;
localparam ST_HOLD  = 2'h3;

//------------------------------------------------------------
// phase lengths in whole cycles
//------------------------------------------------------------
localparam integer SETUP_CYC_I  = `DBH_SETUP_CYC;
localparam integer STROBE_CYC_I = `DBH_STROBE_CYC;
localparam integer CLEAR_CYC_I  = `DBH_CLEAR_CYC;
// the four-bit timer keeps only the low four bits of each load value, so a phase at sixteen cycles loads zero
localparam [3:0]   SETUP_CYC    = SETUP_CYC_I[3:0];
localparam [3:0]   STROBE_CYC   = STROBE_CYC_I[3:0];
localparam [3:0]   CLEAR_CYC    = CLEAR_CYC_I[3:0];

reg [1:0]          state_ff;
reg [1:0]          op_ff;
reg [1:0]          nxt_state;
reg                tmr_load;
reg [3:0]          tmr_val;
wire               tmr_done;
wire               take;
wire               release_en;
wire [NUM_CONV-1:0] load_mask;
wire [NUM_CONV-1:0] update_mask;
wire [NUM_CONV-1:0] nxt_input_latch_enable_n;
wire [NUM_CONV-1:0] nxt_converter_latch_enable_n;

//------------------------------------------------------------
// enable mask
//------------------------------------------------------------
// enable mask for an operation; used by both latch enables
function [NUM_CONV-1:0] en_mask;
    input [1:0]          op;
    input                for_input;
    input [NUM_CONV-1:0] sel;
    begin
        en_mask = {NUM_CONV{1'b0}};
        if (for_input && (op == `DBH_OP_LOAD || op == `DBH_OP_LOAD_UPDATE))
            en_mask = sel;
        if (!for_input && (op == `DBH_OP_UPDATE ||
                           op == `DBH_OP_LOAD_UPDATE))
            en_mask = sel;
    end
endfunction

//------------------------------------------------------------
// phase timer
//------------------------------------------------------------
dbh_timer #(
    .WIDTH    (4)
) u_timer (
    .core_clk (core_clk),
    .reset    (reset),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
);

//------------------------------------------------------------
// sequencer
//------------------------------------------------------------
always @* begin
    nxt_state = state_ff;
    tmr_load  = 1'b0;
    tmr_val   = SETUP_CYC;
    case (state_ff)
        ST_IDLE: begin
            if (req_valid) begin
                nxt_state = ST_SETUP;
                tmr_load  = 1'b1;
            end
        end
        ST_SETUP: begin
            if (tmr_done) begin
                nxt_state = ST_WRITE;
                tmr_load  = 1'b1;
                // clear pulse loads its own length, CLEAR_CYC, for the write phase
                tmr_val   = (op_ff == `DBH_OP_CLEAR) ? CLEAR_CYC
                                                     : STROBE_CYC;
            end
        end
        ST_WRITE: begin
            if (tmr_done) begin
                nxt_state = ST_HOLD;
                tmr_load  = 1'b1;
            end
        end
        ST_HOLD: begin
            if (tmr_done)
                nxt_state = ST_IDLE;
        end
        default: nxt_state = ST_IDLE;
    endcase
end

//------------------------------------------------------------
// request capture
//------------------------------------------------------------
// bus settles a full setup phase before the strobe falls
always @(posedge core_clk or posedge reset) begin
    if (reset) begin
        state_ff    <= ST_IDLE;
        op_ff       <= `DBH_OP_LOAD;
        data_bus_ff <= `DBH_BIPOLAR_ZERO;
    end else begin
        state_ff <= nxt_state;
        if (take) begin
            op_ff       <= req_op;
            data_bus_ff <= req_data;
        end
    end
end

//------------------------------------------------------------
// handshake status
//------------------------------------------------------------
// ready rises with done so the next request can follow at once
always @(posedge core_clk or posedge reset) begin
    if (reset) begin
        req_ready_ff <= 1'b0;
        done_ff      <= 1'b0;
    end else begin
        req_ready_ff <= (nxt_state == ST_IDLE);
        done_ff      <= release_en;
    end
end

//------------------------------------------------------------
// write strobe and clear
//------------------------------------------------------------
always @(posedge core_clk or posedge reset) begin
    if (reset) begin
        write_n_ff <= 1'b1;
        clear_n_ff <= 1'b1;
    end else if (state_ff == ST_SETUP && tmr_done) begin
        // clear and strobe never low together
        if (op_ff == `DBH_OP_CLEAR)
            clear_n_ff <= 1'b0;
        else
            write_n_ff <= 1'b0;
    end else if (state_ff == ST_WRITE && tmr_done) begin
        // strobe held the full minimum so data crosses the enabled latches
        write_n_ff <= 1'b1;
        clear_n_ff <= 1'b1;
    end
end

//------------------------------------------------------------
// latch enables, one pair per converter
//------------------------------------------------------------
// group update: all selected enables share one strobe
assign take        = (state_ff == ST_IDLE) && req_valid;
assign release_en  = (state_ff == ST_HOLD) && tmr_done;
assign load_mask   = en_mask(req_op, 1'b1, req_sel);
assign update_mask = en_mask(req_op, 1'b0, req_sel);

// enables drop back after the strobe so latches hold
genvar gi;
generate
    for (gi = 0; gi < NUM_CONV; gi = gi + 1) begin : g_conv
        assign nxt_input_latch_enable_n[gi] =
            (SINGLE_BUF != 0) ? 1'b0 :
            take              ? ~load_mask[gi] :
            release_en        ? 1'b1 :
                                input_latch_enable_n_ff[gi];
        assign nxt_converter_latch_enable_n[gi] =
            (SINGLE_BUF != 0) ? 1'b0 :
            take              ? ~update_mask[gi] :
            release_en        ? 1'b1 :
                                converter_latch_enable_n_ff[gi];
    end
endgenerate

//------------------------------------------------------------
// enable registers
//------------------------------------------------------------
// single-buffered wiring keeps both enables low even in reset
always @(posedge core_clk or posedge reset) begin
    if (reset) begin
        input_latch_enable_n_ff     <= {NUM_CONV{SINGLE_BUF == 0}};
        converter_latch_enable_n_ff <= {NUM_CONV{SINGLE_BUF == 0}};
    end else begin
        input_latch_enable_n_ff     <= nxt_input_latch_enable_n;
        converter_latch_enable_n_ff <= nxt_converter_latch_enable_n;
    end
end

endmodule

// ==== hw/dbh_timer.v ====
// down counter used to stretch pin phases to whole clock cycles
// assumes the load strobe is a one-cycle pulse from the sequencer
module dbh_timer #(
    parameter WIDTH = 4
) (
    // clock and reset
    input  wire             core_clk,
    input  wire             reset,
    // control
    input  wire             load,
    input  wire [WIDTH-1:0] load_val,
    // status
    output wire             done
);

reg [WIDTH-1:0] cnt_ff;

assign done = (cnt_ff == {WIDTH{1'b0}});

always @(posedge core_clk or posedge reset) begin
    if (reset)
        cnt_ff <= {WIDTH{1'b0}};
    else if (load)
        cnt_ff <= load_val;
    else if (!done)
        cnt_ff <= cnt_ff - {{(WIDTH-1){1'b0}}, 1'b1};
end

endmodule

// ==== tb/dbh_conv_model.sv ====
// converter model: input latch then converter latch
// assumes host pins change just after core_clk rises
module dbh_conv_model (
    // clock
    input  wire logic        core_clk,
    // pins from the host
    input  wire logic [15:0] bus,
    input  wire logic        ile_n,
    input  wire logic        cle_n,
    input  wire logic        write_n,
    input  wire logic        clear_n,
    // latch contents
    output logic      [15:0] in_q,
    output logic      [15:0] code_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // level latches seen at clock rate; no reset, clear zeroes them
    always @(posedge core_clk) begin
        if (!clear_n) begin
            in_q <= 16'h0000;
            code_q <= 16'h0000;
        end else if (!write_n) begin
            if (!ile_n)
                in_q <= bus;
            if (!cle_n)
                code_q <= ile_n ? in_q : bus;
        end
    end
endmodule

// ==== tb/dbh_host_chk.sv ====
// pin timing assertions for the host controller
// assumes bind onto dbh_host, one clock domain
module dbh_host_chk #(
    parameter DATA_W   = 16,
    parameter NUM_CONV = 1,
    parameter SINGLE_BUF = 0
) (
    input wire logic                core_clk,
    input wire logic                reset,
    input wire logic                req_valid,
    input wire logic [1:0]          req_op,
    input wire logic                req_ready_ff,
    input wire logic                done_ff,
    input wire logic [DATA_W-1:0]   data_bus_ff,
    input wire logic [NUM_CONV-1:0] input_latch_enable_n_ff,
    input wire logic [NUM_CONV-1:0] converter_latch_enable_n_ff,
    input wire logic                write_n_ff,
    input wire logic                clear_n_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    wire take = req_valid && req_ready_ff;
    strobe_start_a: assert property (take && req_op != 2'h3
        |-> ##[1:3] !write_n_ff) else $error("no strobe");
    strobe_width_a: assert property ($fell(write_n_ff)
        |-> !write_n_ff [*4]) else $error("strobe short");
    clear_width_a: assert property ($fell(clear_n_ff)
        |-> !clear_n_ff [*4]) else $error("clear short");
    clear_first_a: assert property (!clear_n_ff |-> write_n_ff)
        else $error("strobe during clear");
    bus_hold_a: assert property (!write_n_ff |-> $stable(data_bus_ff))
        else $error("bus moved");
    load_pins_a: assert property (SINGLE_BUF == 0 && take && req_op == 2'h0
        |=> !input_latch_enable_n_ff[0] && converter_latch_enable_n_ff[0])
        else $error("load enables");
    update_pins_a: assert property (SINGLE_BUF == 0 && take && req_op == 2'h1
        |=> input_latch_enable_n_ff[0] && !converter_latch_enable_n_ff[0])
        else $error("update enables");
    done_bound_a: assert property (take |-> ##[1:12] done_ff)
        else $error("no done");
    sb_enables_a: assert property (SINGLE_BUF == 0 ||
        (input_latch_enable_n_ff == '0 && converter_latch_enable_n_ff == '0))
        else $error("single-buffered enables high");
    idle_release_a: assert property (SINGLE_BUF == 0 && req_ready_ff
        |-> &input_latch_enable_n_ff && &converter_latch_enable_n_ff)
        else $error("enables low in idle");
endmodule
bind dbh_host dbh_host_chk #(.DATA_W(DATA_W), .NUM_CONV(NUM_CONV),
    .SINGLE_BUF(SINGLE_BUF)) u_chk (
    .core_clk(core_clk), .reset(reset), .req_valid(req_valid),
    .req_op(req_op), .req_ready_ff(req_ready_ff), .done_ff(done_ff),
    .data_bus_ff(data_bus_ff), .write_n_ff(write_n_ff),
    .input_latch_enable_n_ff(input_latch_enable_n_ff),
    .converter_latch_enable_n_ff(converter_latch_enable_n_ff),
    .clear_n_ff(clear_n_ff));

// ==== tb/tb_top.sv ====
// self-checking bench: host controller driving the converter model
// assumes one converter; dut with default parameters, dut_sb single-buffered
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, reset, req_valid;
    logic [1:0]  req_op;
    logic [15:0] req_data;
    wire         ready, done, wr_n, clr_n, ile_n, cle_n;
    wire  [15:0] bus, in_q, code_q;
    wire         sb_wr, sb_clr, sb_ile, sb_cle;
    wire  [15:0] sb_bus, sb_code;
    logic [15:0] sb_exp;
    int          fails, num_checks;
    // op, bus word, expected input latch, expected code
    logic [49:0] rows [6] = '{{2'h3, 16'h1234, 16'h0000, 16'h0000},
        {2'h0, 16'h7FFF, 16'h7FFF, 16'h0000}, {2'h1, 16'hFFFF, 16'h7FFF,
        16'h7FFF}, {2'h0, 16'h8000, 16'h8000, 16'h7FFF}, {2'h2, 16'hC000,
        16'hC000, 16'hC000}, {2'h3, 16'h5555, 16'h0000, 16'h0000}};
    dbh_host dut (.core_clk(core_clk), .reset(reset), .req_valid(req_valid),
        .req_op(req_op), .req_data(req_data), .req_sel(1'b1),
        .req_ready_ff(ready), .done_ff(done), .data_bus_ff(bus),
        .input_latch_enable_n_ff(ile_n), .write_n_ff(wr_n),
        .converter_latch_enable_n_ff(cle_n), .clear_n_ff(clr_n));
    dbh_conv_model u_conv (.core_clk(core_clk), .bus(bus), .ile_n(ile_n),
        .cle_n(cle_n), .write_n(wr_n), .clear_n(clr_n), .in_q(in_q),
        .code_q(code_q));
    // second controller wired single-buffered, fed the same requests
    dbh_host #(.SINGLE_BUF(1)) dut_sb (.core_clk(core_clk), .reset(reset),
        .req_valid(req_valid), .req_op(req_op), .req_data(req_data),
        .req_sel(1'b1), .req_ready_ff(), .done_ff(), .data_bus_ff(sb_bus),
        .input_latch_enable_n_ff(sb_ile), .write_n_ff(sb_wr),
        .converter_latch_enable_n_ff(sb_cle), .clear_n_ff(sb_clr));
    dbh_conv_model u_conv_sb (.core_clk(core_clk), .bus(sb_bus),
        .ile_n(sb_ile), .cle_n(sb_cle), .write_n(sb_wr), .clear_n(sb_clr),
        .in_q(), .code_q(sb_code));
    task automatic chk(input string nm, input logic [15:0] e, g);
        num_checks++;
        if (g !== e) begin
            $display("wrong value %s exp %h got %h", nm, e, g);
            fails++;
        end
    endtask
    task automatic end_sim();
        if (fails == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ready is high whenever this is entered, so one edge takes it
    task automatic send(input logic [1:0] op, input logic [15:0] d);
        int n;
        {req_valid, req_op, req_data} = {1'b1, op, d};
        @(posedge core_clk);
        #1;
        req_valid = 1'b0;
        for (n = 0; n < 20 && done !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        chk("done", 16'h0001, {15'h0000, done});
        chk("ready", 16'h0001, {15'h0000, ready});
    endtask
    task automatic rst_chk();
        reset = 1'b1;
        repeat (20) @(posedge core_clk);
        #1;
        chk("pins", 16'h000F, {ready, done, ile_n, cle_n, wr_n, clr_n});
        chk("bus", 16'h0000, bus);
        reset = 1'b0;
        @(posedge core_clk);
        #1;
        chk("ready", 16'h0001, {15'h0000, ready});
    endtask
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        #100000;
        fails++;
        end_sim();
    end
    initial begin
        {fails, num_checks, req_valid, req_op, req_data} = '0;
        rst_chk();
        foreach (rows[i]) begin
            send(rows[i][49:48], rows[i][47:32]);
            chk("input latch", rows[i][31:16], in_q);
            chk("code", rows[i][15:0], code_q);
            // single-buffered: every write reaches the code, clear zeroes it
            sb_exp = (rows[i][49:48] == 2'h3) ? 16'h0000 : rows[i][47:32];
            chk("sb code", sb_exp, sb_code);
            chk("sb enables", 16'h0000, {14'h0, sb_ile, sb_cle});
        end
        rst_chk();
        send(2'h2, 16'h0001);
        chk("code", 16'h0001, code_q);
        end_sim();
    end
endmodule
